// ---- rtl/ilc_pkg.sv ----
// Shared constants of the four-level interrupt controller
package ilc_pkg;
  localparam int unsigned NUM_SRC = 14;
  localparam int unsigned NUM_LVL = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_INT_ENABLE_REG_A   = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE_REG_B   = 8'h04;
  localparam logic [7:0] OFS_PRIORITY_LOW_REG_A  = 8'h08;
  localparam logic [7:0] OFS_PRIORITY_HIGH_REG_A = 8'h0C;
  localparam logic [7:0] OFS_PRIORITY_LOW_REG_B  = 8'h10;
  localparam logic [7:0] OFS_PRIORITY_HIGH_REG_B = 8'h14;
  localparam logic [7:0] OFS_TIMER_CTRL_REG     = 8'h18;
  localparam logic [7:0] OFS_STATUS_REG         = 8'h1C;
  // Field positions
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned HALF_SRC      = 7;
  localparam int unsigned TRIG_A_BIT    = 0;
  localparam int unsigned FLAG_A_BIT    = 1;
  localparam int unsigned TRIG_B_BIT    = 2;
  localparam int unsigned FLAG_B_BIT    = 3;
  localparam int unsigned ST_REQ_BIT    = 4;
  localparam int unsigned ST_ID_POS     = 8;
  localparam int unsigned ST_LVL_POS    = 12;
  localparam int unsigned ST_WAKE_BIT   = 16;
  // Source indices of the two external inputs
  localparam logic [3:0] SRC_EXT_A = 4'h0;
  localparam logic [3:0] SRC_EXT_B = 4'h2;
  // Reset values
  localparam logic [13:0] EN_RST   = 14'h0000;
  localparam logic [13:0] PRIO_RST = 14'h0000;
  localparam logic [3:0]  SVC_RST  = 4'h0;
  // Timing in clock cycles
  localparam logic [3:0] MC_CLKS     = 4'h2;
  localparam logic [3:0] GLITCH_CLKS = 4'h3;
  // Polling order among equal levels, rank 0 first, one source index per nibble
  localparam logic [55:0] POLL_ORDER_DEF = 56'hdc_ba98_7654_3210;
endpackage

// ---- rtl/ilc_glitch_filter.sv ----
// Glitch suppression filter for an external interrupt input
`timescale 1ns/100ps
`default_nettype none
module ilc_glitch_filter
  import ilc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  import ilc_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       out;
  } ilc_filt_s;

  ilc_filt_s s_q;
  ilc_filt_s s_d;

  // Output follows only a level that stayed different for GLITCH_CLKS cycles
  always_comb
  begin
    s_d = s_q;
    if (din == s_q.out)
    begin
      s_d.cnt = 4'h0;
    end
    else if (s_q.cnt == GLITCH_CLKS - 4'h1)
    begin
      s_d.cnt = 4'h0;
      s_d.out = din;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '{cnt: 4'h0, out: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
endmodule
`default_nettype wire

// ---- rtl/ilc_top.sv ----
// Four-level interrupt controller with APB registers and two external inputs
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ilc_top
  import ilc_pkg::*;
#(
  parameter logic [55:0] POLL_ORDER = ilc_pkg::POLL_ORDER_DEF
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic [13:0] src_req,
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        cpu_ack,
  input  wire logic        cpu_reti,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_pdown,
  output var  logic        irq_req,
  output var  logic [3:0]  irq_id,
  output var  logic [1:0]  irq_level,
  output var  logic        wake
);
  import ilc_pkg::*;

  typedef struct packed {
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic [3:0]  mc_cnt;
    logic        samp_a;
    logic        samp_b;
    logic        flag_a;
    logic        flag_b;
    logic        global_en;
    logic [13:0] en;
    logic [13:0] pl;
    logic [13:0] ph;
    logic        trig_a;
    logic        trig_b;
    logic [3:0]  in_svc;
    logic        irq_req;
    logic [3:0]  irq_id;
    logic [1:0]  irq_lvl;
    logic        wake;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } ilc_state_s;

  ilc_state_s s_q;
  ilc_state_s s_d;
  logic       filt_b;

  // Level of one source from its two priority bits
  function automatic logic [1:0] src_level(input logic [13:0] ph, input logic [13:0] pl,
                                           input logic [3:0] idx);
    src_level = {ph[idx], pl[idx]};
  endfunction

  // Highest level currently in service, valid flag in bit 2
  function automatic logic [2:0] top_svc(input logic [3:0] svc);
    top_svc = 3'b000;
    for (int i = 0; i < NUM_LVL; i++)
    begin
      if (svc[i])
      begin
        top_svc = {1'b1, 2'(i)};
      end
    end
  endfunction

  // Source index held at one rank of the polling order
  function automatic logic [3:0] poll_src(input logic [55:0] order, input int rank);
    poll_src = order[rank*4 +: 4];
  endfunction

  ilc_glitch_filter u_filt_b
  (
    .clk  (clk),
    .rst  (rst),
    .din  (s_q.sync_b[1]),
    .dout (filt_b)
  );

  logic [13:0] req_vec;
  logic [13:0] pend;
  logic        tick;
  logic        samp_a_n;
  logic        samp_b_n;
  logic        win_found;
  logic [3:0]  win_id;
  logic [1:0]  win_lvl;
  logic [2:0]  svc_top;
  logic        win_ok;
  logic        wr_en;
  logic        lvl_wake;
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb
  begin
    s_d = s_q;
    // Two-stage synchronisers on the pins
    s_d.sync_a = {s_q.sync_a[0], ext_irq_pin_a};
    s_d.sync_b = {s_q.sync_b[0], ext_irq_pin_b};

    // Machine-cycle sample strobe
    tick = (s_q.mc_cnt == MC_CLKS - 4'h1);
    s_d.mc_cnt = tick ? 4'h0 : s_q.mc_cnt + 4'h1;

    // Input a unfiltered, input b through the glitch filter
    samp_a_n = s_q.sync_a[1];
    samp_b_n = filt_b;
    if (tick)
    begin
      s_d.samp_a = samp_a_n;
      s_d.samp_b = samp_b_n;
    end

    // External request flags
    if (!s_q.trig_a)
    begin
      s_d.flag_a = ~s_d.samp_a;
    end
    else
    begin
      if (cpu_ack && s_q.irq_id == SRC_EXT_A)
      begin
        s_d.flag_a = 1'b0;
      end
      if (tick && s_q.samp_a && !samp_a_n)
      begin
        s_d.flag_a = 1'b1;
      end
    end
    if (!s_q.trig_b)
    begin
      s_d.flag_b = ~s_d.samp_b;
    end
    else
    begin
      if (cpu_ack && s_q.irq_id == SRC_EXT_B)
      begin
        s_d.flag_b = 1'b0;
      end
      if (tick && s_q.samp_b && !samp_b_n)
      begin
        s_d.flag_b = 1'b1;
      end
    end

    // Request vector and enable gating
    req_vec = src_req;
    req_vec[SRC_EXT_A] = s_q.flag_a;
    req_vec[SRC_EXT_B] = s_q.flag_b;
    pend = req_vec & s_q.en & {NUM_SRC{s_q.global_en}};

    // Arbitration: highest level, ties by polling rank
    win_found = 1'b0;
    win_id = 4'h0;
    win_lvl = 2'b00;
    for (int k = 0; k < NUM_SRC; k++)
    begin
      if (pend[poll_src(POLL_ORDER, k)])
      begin
        if (!win_found || src_level(s_q.ph, s_q.pl, poll_src(POLL_ORDER, k)) > win_lvl)
        begin
          win_found = 1'b1;
          win_id = poll_src(POLL_ORDER, k);
          win_lvl = src_level(s_q.ph, s_q.pl, poll_src(POLL_ORDER, k));
        end
      end
    end

    // Preemption only by a strictly higher level; level 3 is never exceeded
    svc_top = top_svc(s_q.in_svc);
    win_ok = win_found && (!svc_top[2] || win_lvl > svc_top[1:0]);

    // In-service tracking
    if (cpu_reti && svc_top[2])
    begin
      s_d.in_svc[svc_top[1:0]] = 1'b0;
    end
    if (cpu_ack && s_q.irq_req)
    begin
      s_d.in_svc[s_q.irq_lvl] = 1'b1;
    end

    // Request to the core, withdrawn in the cycle after it is taken
    s_d.irq_req = win_ok && !cpu_ack && !cpu_reti;
    s_d.irq_id = win_ok ? win_id : s_q.irq_id;
    s_d.irq_lvl = win_ok ? win_lvl : s_q.irq_lvl;

    // Wake-up: level-mode external input wakes both modes, others only idle
    lvl_wake = (!s_q.trig_a && s_q.flag_a && s_q.en[SRC_EXT_A]) ||
               (!s_q.trig_b && s_q.flag_b && s_q.en[SRC_EXT_B]);
    s_d.wake = (cpu_pdown && lvl_wake) || (cpu_idle && |pend);

    // APB slave: one wait-free access phase after each setup
    s_d.pready = psel && !penable && !s_q.pready;
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFS_INT_ENABLE_REG_A:
      begin
        rd_val[6:0] = s_q.en[6:0];
        rd_val[GLOBAL_EN_BIT] = s_q.global_en;
      end
      OFS_INT_ENABLE_REG_B:    rd_val[6:0] = s_q.en[13:7];
      OFS_PRIORITY_LOW_REG_A:  rd_val[6:0] = s_q.pl[6:0];
      OFS_PRIORITY_HIGH_REG_A: rd_val[6:0] = s_q.ph[6:0];
      OFS_PRIORITY_LOW_REG_B:  rd_val[6:0] = s_q.pl[13:7];
      OFS_PRIORITY_HIGH_REG_B: rd_val[6:0] = s_q.ph[13:7];
      OFS_TIMER_CTRL_REG:
      begin
        rd_val[TRIG_A_BIT] = s_q.trig_a;
        rd_val[FLAG_A_BIT] = s_q.flag_a;
        rd_val[TRIG_B_BIT] = s_q.trig_b;
        rd_val[FLAG_B_BIT] = s_q.flag_b;
      end
      OFS_STATUS_REG:
      begin
        rd_val[3:0] = s_q.in_svc;
        rd_val[ST_REQ_BIT] = s_q.irq_req;
        rd_val[ST_ID_POS +: 4] = s_q.irq_id;
        rd_val[ST_LVL_POS +: 2] = s_q.irq_lvl;
        rd_val[ST_WAKE_BIT] = s_q.wake;
      end
      default: rd_hit = 1'b0;
    endcase
    if (psel && !penable)
    begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
      s_d.pslverr = !rd_hit;
    end

    wr_en = psel && penable && pwrite && s_q.pready;
    if (wr_en)
    begin
      unique case (paddr)
        OFS_INT_ENABLE_REG_A:
        begin
          s_d.en[6:0] = pwdata[6:0];
          s_d.global_en = pwdata[GLOBAL_EN_BIT];
        end
        OFS_INT_ENABLE_REG_B:    s_d.en[13:7] = pwdata[6:0];
        OFS_PRIORITY_LOW_REG_A:  s_d.pl[6:0] = pwdata[6:0];
        OFS_PRIORITY_HIGH_REG_A: s_d.ph[6:0] = pwdata[6:0];
        OFS_PRIORITY_LOW_REG_B:  s_d.pl[13:7] = pwdata[6:0];
        OFS_PRIORITY_HIGH_REG_B: s_d.ph[13:7] = pwdata[6:0];
        OFS_TIMER_CTRL_REG:
        begin
          s_d.trig_a = pwdata[TRIG_A_BIT];
          s_d.trig_b = pwdata[TRIG_B_BIT];
        end
        default:
        begin
          s_d.global_en = s_d.global_en;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q.sync_a    <= 2'b11;
      s_q.sync_b    <= 2'b11;
      s_q.mc_cnt    <= 4'h0;
      s_q.samp_a    <= 1'b1;
      s_q.samp_b    <= 1'b1;
      s_q.flag_a    <= 1'b0;
      s_q.flag_b    <= 1'b0;
      s_q.global_en <= 1'b0;
      s_q.en        <= EN_RST;
      s_q.pl        <= PRIO_RST;
      s_q.ph        <= PRIO_RST;
      s_q.trig_a    <= 1'b0;
      s_q.trig_b    <= 1'b0;
      s_q.in_svc    <= SVC_RST;
      s_q.irq_req   <= 1'b0;
      s_q.irq_id    <= 4'h0;
      s_q.irq_lvl   <= 2'b00;
      s_q.wake      <= 1'b0;
      s_q.pready    <= 1'b0;
      s_q.prdata    <= 32'h0000_0000;
      s_q.pslverr   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready    = s_q.pready;
  assign prdata    = s_q.prdata;
  assign pslverr   = s_q.pslverr;
  assign irq_req   = s_q.irq_req;
  assign irq_id    = s_q.irq_id;
  assign irq_level = s_q.irq_lvl;
  assign wake      = s_q.wake;
endmodule
`default_nettype wire

// ---- tb/ilc_top_asserts.sv ----
// Port assertions for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module ilc_top_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_ack,
  input wire logic        cpu_reti,
  input wire logic        cpu_idle,
  input wire logic        cpu_pdown,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level,
  input wire logic        wake
);
  logic [3:0] svc_q;
  // Levels in service; a return drops the highest
  always_ff @(posedge clk)
    if (rst)
      svc_q <= 4'h0;
    else if (cpu_ack && irq_req)
      svc_q <= svc_q | (4'h1 << irq_level);
    else if (cpu_reti)
      svc_q <= svc_q[3] ? svc_q & 4'h7 : svc_q[2] ? svc_q & 4'h3 : svc_q & 4'h1 & {4{svc_q[1]}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  a_upper_zero: assert property (pready && paddr < 8'h18 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ack_drops: assert property (cpu_ack && irq_req |=> !irq_req)
    else $error("request kept after ack");
  a_reti_drops: assert property (cpu_reti |=> !irq_req)
    else $error("request kept after return");
  a_only_higher: assert property (irq_req |-> (svc_q >> irq_level) == 4'h0)
    else $error("request not above service level");
  a_top_blocks: assert property (svc_q[3] |-> !irq_req)
    else $error("request during top level service");
  a_wake_cause: assert property (wake |-> $past(cpu_idle || cpu_pdown))
    else $error("wake without low power state");
endmodule
bind ilc_top ilc_top_asserts i_ilc_top_asserts (.clk, .rst, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .cpu_ack, .cpu_reti, .cpu_idle, .cpu_pdown, .irq_req, .irq_level, .wake);
`default_nettype wire

// ---- tb/ilc_cpu_model.sv ----
// Core model that takes and returns interrupts
`timescale 1ns/100ps
`default_nettype none
module ilc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic       en,
  input  wire logic [3:0] dly,
  input  wire logic [7:0] svc_len,
  output var  logic       cpu_ack,
  output var  logic       cpu_reti,
  output var  logic [7:0] n_ack
);
  logic [3:0] w_q;
  logic [3:0] depth_q;
  logic [7:0] t_q;
  // Ack after dly cycles of request; each nested service returns after svc_len
  always_ff @(posedge clk)
    if (rst)
      {cpu_ack, cpu_reti, w_q, depth_q, t_q, n_ack} <= '0;
    else
    begin
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
      w_q <= (irq_req && !cpu_ack) ? w_q + 4'h1 : 4'h0;
      if (en && irq_req && !cpu_ack && !cpu_reti && w_q >= dly)
      begin
        cpu_ack <= 1'b1;
        depth_q <= depth_q + 4'h1;
        t_q <= 8'h00;
        n_ack <= n_ack + 8'h01;
      end
      else if (depth_q != 4'h0 && !cpu_ack)
      begin
        t_q <= t_q + 8'h01;
        if (t_q == svc_len)
        begin
          cpu_reti <= 1'b1;
          depth_q <= depth_q - 4'h1;
          t_q <= 8'h00;
        end
      end
    end
endmodule
`default_nettype wire

// ---- tb/four_level_interrupt_controller_tb_top.sv ----
// Testbench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, s) begin checks++; if ((s) !== (x)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, x, s); end end
module four_level_interrupt_controller_tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, cpu_en;
  logic        ext_irq_pin_a, ext_irq_pin_b, cpu_ack, cpu_reti, cpu_idle, cpu_pdown;
  logic        irq_req, wake;
  logic [7:0]  paddr, n_ack, n0;
  logic [31:0] pwdata, prdata, r;
  logic [13:0] src_req;
  logic [3:0]  irq_id, dly;
  logic [1:0]  irq_level;
  int          err_total, checks;
  ilc_top i_ilc_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .src_req, .ext_irq_pin_a, .ext_irq_pin_b, .cpu_ack, .cpu_reti, .cpu_idle,
    .cpu_pdown, .irq_req, .irq_id, .irq_level, .wake);
  ilc_cpu_model i_ilc_cpu_model (.clk, .rst, .irq_req, .en(cpu_en), .dly, .svc_len(8'd40),
    .cpu_ack, .cpu_reti, .n_ack);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready === 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    tick(2);
    apb(1'b0, a, 32'h0);
    `CHK(n, x, r & m)
  endtask
  task give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    tick(5000);
    err_total++;
    give_verdict;
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, src_req} = '0;
    {cpu_idle, cpu_pdown, cpu_en} = '0;
    rst = 1'b1;
    ext_irq_pin_a = 1'b1;
    ext_irq_pin_b = 1'b1;
    dly = 4'h3;
    tick(4);
    rst <= 1'b0;
    for (int a = 0; a < 36; a += 4)
      rd_chk("reset", a[7:0], 32'hFFFF_FFFF, 32'h0);
    `CHK("slverr", 1'b1, e)
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    rd_chk("en_b", 8'h04, 32'hFFFF_FFFF, 32'h7F);
    src_req <= 14'h0020;
    for (int l = 0; l < 4; l++)
    begin
      apb(1'b1, 8'h08, {26'h0, l[0], 5'h0});
      apb(1'b1, 8'h0C, {26'h0, l[1], 5'h0});
      rd_chk("lvl", 8'h1C, 32'h3F10, {18'h0, l[1:0], 12'h510});
    end
    apb(1'b1, 8'h00, 32'h7F);
    rd_chk("global", 8'h1C, 32'h10, 32'h0);
    apb(1'b1, 8'h00, 32'hFF);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h44);
    apb(1'b1, 8'h14, 32'h44);
    src_req <= 14'h2020;
    rd_chk("multi", 8'h1C, 32'h3F10, 32'h3D10);
    `CHK("irq_id", 4'hD, irq_id)
    `CHK("irq_level", 2'h3, irq_level)
    src_req <= 14'h2220;
    rd_chk("poll", 8'h1C, 32'h3F10, 32'h3910);
    src_req <= 14'h0020;
    cpu_en <= 1'b1;
    tick(8);
    rd_chk("svc1", 8'h1C, 32'h1F, 32'h02);
    src_req <= 14'h2220;
    tick(8);
    rd_chk("svc3", 8'h1C, 32'h1F, 32'h0A);
    src_req <= 14'h0;
    tick(120);
    rd_chk("ret", 8'h1C, 32'h1F, 32'h0);
    cpu_en <= 1'b0;
    ext_irq_pin_a <= 1'b0;
    cpu_pdown <= 1'b1;
    tick(8);
    rd_chk("lvl_a", 8'h18, 32'hF, 32'h2);
    rd_chk("wake_pd", 8'h1C, 32'h1_0F10, 32'h1_0010);
    n0 = n_ack;
    cpu_en <= 1'b1;
    tick(120);
    cpu_en <= 1'b0;
    `CHK("rerun", 1'b1, n_ack - n0 > 8'd1)
    ext_irq_pin_a <= 1'b1;
    tick(60);
    rd_chk("clr_a", 8'h18, 32'hF, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    ext_irq_pin_a <= 1'b0;
    tick(6);
    ext_irq_pin_a <= 1'b1;
    rd_chk("edge_a", 8'h18, 32'hF, 32'h3);
    rd_chk("wake_edge", 8'h1C, 32'h1_0000, 32'h0);
    cpu_pdown <= 1'b0;
    dly <= 4'h0;
    cpu_en <= 1'b1;
    tick(6);
    cpu_en <= 1'b0;
    rd_chk("ack_a", 8'h18, 32'hF, 32'h1);
    // Input b in edge mode so that a glitch that got through would stay latched
    apb(1'b1, 8'h18, 32'h4);
    ext_irq_pin_b <= 1'b0;
    tick(2);
    ext_irq_pin_b <= 1'b1;
    tick(12);
    rd_chk("glitch", 8'h18, 32'hF, 32'h4);
    ext_irq_pin_b <= 1'b0;
    cpu_idle <= 1'b1;
    tick(12);
    rd_chk("pin_b", 8'h18, 32'hF, 32'hC);
    rd_chk("wake_idle", 8'h1C, 32'h1_0000, 32'h1_0000);
    give_verdict;
  end
endmodule
`default_nettype wire
